// ==== shared/swc_defs.svh ====
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH

// Word offsets of the configuration words in the serial memory.
`define SWC_OFS_ENABLE      6'h00
`define SWC_OFS_CTL_ONE     6'h02
`define SWC_OFS_CTL_TWO     6'h03
`define SWC_OFS_XCVR        6'h04

// Pattern that word zero must hold before any other word is taken.
`define SWC_ENABLE_PATTERN  16'h55aa

// Reset values of the three words, in-scope fields only.
`define SWC_RST_CTL_ONE     16'h0000
`define SWC_RST_CTL_TWO     16'h1812
`define SWC_RST_XCVR        16'h0600

// Bits that carry a field; every other position is dropped on load.
`define SWC_MSK_CTL_ONE     16'h0004
`define SWC_MSK_CTL_TWO     16'h1efe
`define SWC_MSK_XCVR        16'hff00

// Field positions in switch_control_one.
`define SWC_BIT_STORM       2

// Field positions in switch_control_two.
`define SWC_BIT_DUPLEX      12
`define SWC_BIT_SPEED       11
`define SWC_BIT_PAUSE       10
`define SWC_BIT_EXT_EN      9
`define SWC_BIT_DROP        7
`define SWC_HASH_HI         6
`define SWC_HASH_LO         5
`define SWC_AGE_HI          4
`define SWC_AGE_LO          3
`define SWC_BIT_FWD_ALL     2
`define SWC_BIT_SHORT_BO    1

// Field positions in transceiver_control.
`define SWC_ODD_HI          15
`define SWC_ODD_LO          14
`define SWC_EVEN_HI         13
`define SWC_EVEN_LO         12
`define SWC_BIT_FORCE       11
`define SWC_BIT_FEF         10
`define SWC_BIT_PWR_SAVE    9
`define SWC_BIT_XOVER       8

// Entry expiry times in seconds.
`define SWC_AGE_NONE_S      9'd0
`define SWC_AGE_SHORT_S     9'd120
`define SWC_AGE_MID_S       9'd240
`define SWC_AGE_LONG_S      9'd480

// Hash and port option codes.
`define SWC_HASH_CRC_CRC    2'b10
`define SWC_OPT_FIBER_FULL  2'b10
`define SWC_OPT_FIBER_HALF  2'b11

`endif

// ==== shared/swc_pkg.sv ====
package swc_pkg;

    // Phases of the configuration bank.
    typedef enum logic [1:0] {
        SWC_ST_RESET,
        SWC_ST_LOAD,
        SWC_ST_RUN
    } swc_state_t;

    typedef logic [15:0] swc_word_t;

endpackage : swc_pkg

// ==== hw/swc_word_gate.sv ====
`timescale 1ns/1ns
`include "swc_defs.svh"

module swc_word_gate
    import swc_pkg::*;
#(
    parameter int IDX_W = 6
) (
    input  wire logic             core_clk_i,   // System clock.
    input  wire logic             rst_i,        // Synchronous reset, active high.
    input  wire logic             ce_i,         // Clock enable.
    input  wire logic             start_i,      // Begin a memory read pass.
    input  wire logic             word_vld_i,   // Memory word strobe.
    input  wire logic [IDX_W-1:0] word_idx_i,   // Memory word index.
    input  wire swc_word_t        word_i,       // Memory word data.
    input  wire logic             done_i,       // Memory read pass finished.
    output logic                  accept_o,     // Word may be written to the bank.
    output logic                  valid_o,      // Enable pattern seen.
    output logic                  busy_o        // Read pass in progress.
);

    // Refuse an index too narrow to address the configuration words.
    if (IDX_W < 3) begin : g_idx_check
        $error("IDX_W too small to reach the configuration words");
    end

    logic checked;

    // Decode of the enable word.
    wire is_word_zero = word_vld_i && (word_idx_i == IDX_W'(`SWC_OFS_ENABLE));
    wire pattern_ok   = (word_i == `SWC_ENABLE_PATTERN);

    // Only words after a good enable word reach the bank.
    assign accept_o = busy_o && valid_o && word_vld_i && !is_word_zero; // R15

    // Track the pass and the outcome of the pattern check.
    always_ff @(posedge core_clk_i) begin
        if (ce_i && rst_i) begin
            busy_o  <= 1'b0;
            valid_o <= 1'b0;
            checked <= 1'b0;
        end else if (ce_i) begin
            if (start_i) begin
                busy_o  <= 1'b1;
                valid_o <= 1'b0;
                checked <= 1'b0;
            end else if (busy_o) begin
                if (is_word_zero && !checked) begin
                    valid_o <= pattern_ok; // R15
                    checked <= 1'b1;
                end
                if (done_i) begin
                    busy_o <= 1'b0;
                end
            end
        end
    end

    // A bad pattern never lets a word through.
    bad_pattern_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R15
        (ce_i && busy_o && is_word_zero && !checked && !pattern_ok && !start_i)
        |=> !valid_o)
        else $error("word gate opened on a bad enable pattern");

endmodule : swc_word_gate

// ==== hw/swc_config_bank.sv ====
// Operation
// [R01] Storm guard bit set lets the switch drop arrivals over the broadcast threshold.
// [R02] External port duplex bit: one full duplex, zero half; default full.
// [R03] External port speed bit: one selects 10M (default), zero 100M.
// [R04] External port flow control only while its pause bit is one; default off.
// [R05] External port used only while its enable bit is one; default off.
// [R06] Discard bit one abandons a frame after 16 consecutive collisions.
// [R07] Hash pair taken at end of load: 00/01 direct-CRC, 10 CRC-CRC, 11 reserved.
// [R08] Expiry select: 00 none, 01 120s, 10 240s default, 11 480s.
// [R09] Forward-everything bit forwards all frames; test only, loader keeps zero. The bank loads it from straps and memory.
// [R10] Short backoff bit one (default) caps backoff at 8-slot time.
// [R11] Odd option: 00 all odd ports negotiate; 10/11 port 7 fiber full/half. The bank sets port 7 fiber only while the force bit is zero.
// [R12] Even option: 00 all even ports negotiate; 10/11 port 6 fiber full/half. The bank sets port 6 fiber only while the force bit is zero.
// [R13] Far-end fault signalling only while its enable bit is one; default one.
// [R14] Negotiation power save while its bit is one; loader keeps default one. The bank loads it from straps and memory.
// [R15] Memory words accepted only when word zero holds 55AA, else straps kept.
// [R16] A valid memory value overrides the strap value of the same field.
// [R17] At end of reset straps are latched, then the memory read begins.
// [R18] Reserved bit positions are dropped on load and affect nothing.
`timescale 1ns/1ns
`include "swc_defs.svh"

module swc_config_bank
    import swc_pkg::*;
#(
    parameter int IDX_W = 6
) (
    input  wire logic             core_clk_i,        // System clock, 100 MHz.
    input  wire logic             rst_i,             // Synchronous reset, active high.
    input  wire logic             ce_i,              // Clock enable, freezes all state.
    input  wire swc_word_t        strap_ctl_one_i,   // Strap levels for control word one.
    input  wire swc_word_t        strap_ctl_two_i,   // Strap levels for control word two.
    input  wire swc_word_t        strap_xcvr_i,      // Strap levels for transceiver word.
    input  wire logic             ee_word_vld_i,     // Memory word strobe.
    input  wire logic [IDX_W-1:0] ee_word_idx_i,     // Memory word index.
    input  wire swc_word_t        ee_word_i,         // Memory word data.
    input  wire logic             ee_done_i,         // Memory read pass finished.
    output logic                  ee_start_o,        // Pulse: begin memory read.
    output logic                  ee_valid_o,        // Memory contents were accepted.
    output logic                  cfg_ready_o,       // Configuration settled.
    output swc_word_t             switch_control_one_o, // Word one as held.
    output swc_word_t             switch_control_two_o, // Word two as held.
    output swc_word_t             transceiver_control_o, // Transceiver word as held.
    output logic                  broadcast_storm_guard_en_o, // Storm guard on.
    output logic                  ext_port_duplex_o,  // One full, zero half.
    output logic                  ext_port_speed_sel_o, // One 10M, zero 100M.
    output logic                  ext_port_pause_en_o, // Flow control on.
    output logic                  ext_port_enable_o,  // External port in use.
    output logic                  excess_collision_discard_o, // Drop after 16 tries.
    output logic [1:0]            lookup_hash_select_o, // Hash code as latched.
    output logic                  hash_crc_first_o,   // First level uses CRC.
    output logic [1:0]            entry_expiry_select_o, // Expiry code.
    output logic [8:0]            entry_expiry_secs_o, // Expiry time in seconds, 0 none.
    output logic                  forward_everything_o, // Forward all frames.
    output logic                  short_backoff_en_o, // Backoff capped at 8 slots.
    output logic [1:0]            odd_port_option_o,  // Odd port option code.
    output logic [1:0]            even_port_option_o, // Even port option code.
    output logic                  port7_fiber_o,      // Port 7 runs as fiber.
    output logic                  port7_fiber_full_o, // Port 7 fiber full duplex.
    output logic                  port6_fiber_o,      // Port 6 runs as fiber.
    output logic                  port6_fiber_full_o, // Port 6 fiber full duplex.
    output logic                  remote_fault_en_o,  // Far-end fault signalling on.
    output logic                  neg_power_save_en_o, // Power-saving negotiation on.
    output logic                  crossover_auto_en_o // Automatic crossover on.
);

    swc_state_t state;
    swc_word_t  ctl_one;
    swc_word_t  ctl_two;
    swc_word_t  xcvr;
    logic       rst_q;
    logic       accept;
    logic       gate_valid;
    logic       gate_busy;

    // Judges the enable word and opens the path for later words.
    swc_word_gate #(
        .IDX_W      (IDX_W)
    ) u_gate (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .start_i    (ee_start_o),
        .word_vld_i (ee_word_vld_i),
        .word_idx_i (ee_word_idx_i),
        .word_i     (ee_word_i),
        .done_i     (ee_done_i),
        .accept_o   (accept),
        .valid_o    (gate_valid),
        .busy_o     (gate_busy)
    );

    // Phase and write decode.
    wire end_of_reset = rst_q && (state == SWC_ST_RESET);
    wire load_done    = (state == SWC_ST_LOAD) && ee_start_o == 1'b0 && !gate_busy;
    wire wr_one       = accept && (ee_word_idx_i == IDX_W'(`SWC_OFS_CTL_ONE));
    wire wr_two       = accept && (ee_word_idx_i == IDX_W'(`SWC_OFS_CTL_TWO));
    wire wr_xcvr      = accept && (ee_word_idx_i == IDX_W'(`SWC_OFS_XCVR));

    // Field selection from the held words.
    wire [1:0] hash_code = ctl_two[`SWC_HASH_HI:`SWC_HASH_LO];
    wire [1:0] age_code  = ctl_two[`SWC_AGE_HI:`SWC_AGE_LO];
    wire [1:0] odd_code  = xcvr[`SWC_ODD_HI:`SWC_ODD_LO];
    wire [1:0] even_code = xcvr[`SWC_EVEN_HI:`SWC_EVEN_LO];
    wire       fixed_off = !xcvr[`SWC_BIT_FORCE];
    wire       odd_fiber  = fixed_off && odd_code[1]; // R11
    wire       even_fiber = fixed_off && even_code[1]; // R12

    // Expiry seconds from the select code.
    logic [8:0] next_expiry_secs;
    always_comb begin
        unique case (age_code) // R08
            2'b00: next_expiry_secs = `SWC_AGE_NONE_S;
            2'b01: next_expiry_secs = `SWC_AGE_SHORT_S;
            2'b10: next_expiry_secs = `SWC_AGE_MID_S;
            2'b11: next_expiry_secs = `SWC_AGE_LONG_S;
        endcase
    end

    // Remembers that reset was high in the previous enabled cycle.
    always_ff @(posedge core_clk_i) begin
        if (ce_i && rst_i) begin
            rst_q <= 1'b1;
        end else if (ce_i) begin
            rst_q <= 1'b0;
        end
    end

    // Phase sequencing: straps, then memory read, then settled.
    always_ff @(posedge core_clk_i) begin
        if (ce_i && rst_i) begin
            state      <= SWC_ST_RESET;
            ee_start_o <= 1'b0;
        end else if (ce_i) begin
            ee_start_o <= end_of_reset; // R17
            unique case (state)
                SWC_ST_RESET: if (end_of_reset) begin
                    state <= SWC_ST_LOAD;
                end
                SWC_ST_LOAD: if (load_done) begin
                    state <= SWC_ST_RUN;
                end
                SWC_ST_RUN: state <= SWC_ST_RUN;
            endcase
        end
    end

    // Configuration words: defaults, then straps, then memory contents.
    always_ff @(posedge core_clk_i) begin
        if (ce_i && rst_i) begin
            ctl_one <= `SWC_RST_CTL_ONE;
            ctl_two <= `SWC_RST_CTL_TWO;
            xcvr    <= `SWC_RST_XCVR;
        end else if (ce_i) begin
            if (end_of_reset) begin
                ctl_one <= strap_ctl_one_i & `SWC_MSK_CTL_ONE; // R17 R18
                ctl_two <= strap_ctl_two_i & `SWC_MSK_CTL_TWO; // R17 R18
                xcvr    <= strap_xcvr_i & `SWC_MSK_XCVR; // R17 R18
            end else begin
                if (wr_one) begin
                    ctl_one <= ee_word_i & `SWC_MSK_CTL_ONE; // R16 R18
                end
                if (wr_two) begin
                    ctl_two <= ee_word_i & `SWC_MSK_CTL_TWO; // R16 R18
                end
                if (wr_xcvr) begin
                    xcvr <= ee_word_i & `SWC_MSK_XCVR; // R16 R18
                end
            end
        end
    end

    // Hash choice is taken once, when loading ends.
    always_ff @(posedge core_clk_i) begin
        if (ce_i && rst_i) begin
            lookup_hash_select_o <= 2'b00;
            hash_crc_first_o     <= 1'b0;
            ee_valid_o           <= 1'b0;
            cfg_ready_o          <= 1'b0;
        end else if (ce_i && load_done) begin
            lookup_hash_select_o <= hash_code; // R07
            hash_crc_first_o     <= (hash_code == `SWC_HASH_CRC_CRC); // R07
            ee_valid_o           <= gate_valid; // R15
            cfg_ready_o          <= 1'b1;
        end
    end

    // Registered copies of every field except the hash choice for the switch core.
    always_ff @(posedge core_clk_i) begin
        if (ce_i && rst_i) begin
            switch_control_one_o       <= `SWC_RST_CTL_ONE;
            switch_control_two_o       <= `SWC_RST_CTL_TWO;
            transceiver_control_o      <= `SWC_RST_XCVR;
            broadcast_storm_guard_en_o <= 1'b0;
            ext_port_duplex_o          <= 1'b1;
            ext_port_speed_sel_o       <= 1'b1;
            ext_port_pause_en_o        <= 1'b0;
            ext_port_enable_o          <= 1'b0;
            excess_collision_discard_o <= 1'b0;
            entry_expiry_select_o      <= 2'b10;
            entry_expiry_secs_o        <= `SWC_AGE_MID_S;
            forward_everything_o       <= 1'b0;
            short_backoff_en_o         <= 1'b1;
            odd_port_option_o          <= 2'b00;
            even_port_option_o         <= 2'b00;
            port7_fiber_o              <= 1'b0;
            port7_fiber_full_o         <= 1'b0;
            port6_fiber_o              <= 1'b0;
            port6_fiber_full_o         <= 1'b0;
            remote_fault_en_o          <= 1'b1;
            neg_power_save_en_o        <= 1'b1;
            crossover_auto_en_o        <= 1'b0;
        end else if (ce_i) begin
            switch_control_one_o       <= ctl_one;
            switch_control_two_o       <= ctl_two;
            transceiver_control_o      <= xcvr;
            broadcast_storm_guard_en_o <= ctl_one[`SWC_BIT_STORM]; // R01
            ext_port_duplex_o          <= ctl_two[`SWC_BIT_DUPLEX]; // R02
            ext_port_speed_sel_o       <= ctl_two[`SWC_BIT_SPEED]; // R03
            ext_port_pause_en_o        <= ctl_two[`SWC_BIT_PAUSE]; // R04
            ext_port_enable_o          <= ctl_two[`SWC_BIT_EXT_EN]; // R05
            excess_collision_discard_o <= ctl_two[`SWC_BIT_DROP]; // R06
            entry_expiry_select_o      <= age_code; // R08
            entry_expiry_secs_o        <= next_expiry_secs; // R08
            forward_everything_o       <= ctl_two[`SWC_BIT_FWD_ALL]; // R09
            short_backoff_en_o         <= ctl_two[`SWC_BIT_SHORT_BO]; // R10
            odd_port_option_o          <= odd_code; // R11
            even_port_option_o         <= even_code; // R12
            port7_fiber_o              <= odd_fiber; // R11
            port7_fiber_full_o         <= odd_fiber && !odd_code[0]; // R11
            port6_fiber_o              <= even_fiber; // R12
            port6_fiber_full_o         <= even_fiber && !even_code[0]; // R12
            remote_fault_en_o          <= xcvr[`SWC_BIT_FEF]; // R13
            neg_power_save_en_o        <= xcvr[`SWC_BIT_PWR_SAVE]; // R14
            crossover_auto_en_o        <= xcvr[`SWC_BIT_XOVER];
        end
    end

    storm_guard_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R01
        ce_i |=> broadcast_storm_guard_en_o == $past(ctl_one[`SWC_BIT_STORM]))
        else $error("storm guard output does not follow its bit");

    ext_port_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R02
        (ce_i && wr_two) ##1 ce_i |=>
        {ext_port_duplex_o, ext_port_speed_sel_o, ext_port_pause_en_o, ext_port_enable_o}
        == $past(ee_word_i[`SWC_BIT_DUPLEX:`SWC_BIT_EXT_EN], 2))
        else $error("external port fields not taken from the written word");

    strap_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R17
        (ce_i && end_of_reset) |=> ee_start_o && ctl_two == ($past(strap_ctl_two_i)
        & `SWC_MSK_CTL_TWO))
        else $error("straps not latched with the read start");

    reject_word_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R15
        (ce_i && ee_word_vld_i && !gate_valid && !end_of_reset) |=> $stable(ctl_two))
        else $error("word written without a valid enable pattern");

    hash_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R07
        (state == SWC_ST_RUN) ##1 (state == SWC_ST_RUN) |-> $stable(lookup_hash_select_o))
        else $error("hash choice changed after loading");

    expiry_secs_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R08
        (ce_i && age_code == 2'b11) |=> entry_expiry_secs_o == `SWC_AGE_LONG_S)
        else $error("expiry time wrong for the longest code");

    fiber_port_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R11
        (ce_i && fixed_off && odd_code == `SWC_OPT_FIBER_HALF) |=>
        port7_fiber_o && !port7_fiber_full_o)
        else $error("port 7 fiber half duplex not selected");

    reserved_bits_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R18
        ((xcvr & ~`SWC_MSK_XCVR) == 16'h0000) && ((ctl_one & ~`SWC_MSK_CTL_ONE) == 16'h0000))
        else $error("reserved bit held in a configuration word");

endmodule : swc_config_bank

// ==== sim/swc_mem_model.sv ====
`timescale 1ns/1ns
module swc_mem_model
    import swc_pkg::*;
(
    input  wire logic       core_clk_i, // System clock.
    input  wire logic       rst_i,      // Reset, active high.
    input  wire logic       start_i,    // Read request from the bank.
    input  wire logic [3:0] gap_i,      // Idle cycles before each word.
    input  wire swc_word_t  pattern_i,  // Content of word zero.
    input  wire swc_word_t  w2_i,       // Content of word two.
    input  wire swc_word_t  w3_i,       // Content of word three.
    input  wire swc_word_t  w4_i,       // Content of word four.
    output logic            vld_o,      // Word strobe.
    output logic [5:0]      idx_o,      // Word index.
    output swc_word_t       word_o,     // Word data.
    output logic            done_o      // Pass finished, with the last word.
);
    logic [2:0] step;
    logic [3:0] wait_n;

    // Quiet outputs before the first falling edge.
    initial begin
        vld_o = 1'b0;
        done_o = 1'b0;
        idx_o = 6'h00;
        word_o = 16'h0000;
        step = 3'h0;
        wait_n = 4'h0;
    end

    // Words leave on the falling edge; idle data toggles so a stale word never looks valid.
    always @(negedge core_clk_i) begin
        vld_o <= 1'b0;
        done_o <= 1'b0;
        word_o <= ~word_o;
        if (rst_i) begin
            step <= 3'h0;
        end else if (start_i) begin
            step <= 3'h1;
            wait_n <= gap_i;
        end else if (step != 3'h0 && wait_n != 4'h0) begin
            wait_n <= wait_n - 4'h1;
        end else if (step != 3'h0) begin
            vld_o <= 1'b1;
            idx_o <= (step == 3'h1) ? 6'h00 : {3'h0, step};
            word_o <= (step == 3'h1) ? pattern_i : (step == 3'h2) ? w2_i :
                      (step == 3'h3) ? w3_i : w4_i;
            done_o <= (step == 3'h4);
            step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
            wait_n <= gap_i;
        end
    end
endmodule : swc_mem_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`include "swc_defs.svh"
module testbench
    import swc_pkg::*;
;
    logic core_clk_i, rst_i, ce_i, ee_word_vld_i, ee_done_i, ee_start_o, ee_valid_o, cfg_ready_o;
    logic [5:0] ee_word_idx_i;
    swc_word_t strap_ctl_one_i, strap_ctl_two_i, strap_xcvr_i, ee_word_i, pat, m2, m3, m4;
    swc_word_t switch_control_one_o, switch_control_two_o, transceiver_control_o;
    logic broadcast_storm_guard_en_o, ext_port_duplex_o, ext_port_speed_sel_o, ext_port_pause_en_o;
    logic ext_port_enable_o, excess_collision_discard_o, hash_crc_first_o, forward_everything_o;
    logic short_backoff_en_o, port7_fiber_o, port7_fiber_full_o, port6_fiber_o, port6_fiber_full_o;
    logic remote_fault_en_o, neg_power_save_en_o, crossover_auto_en_o;
    logic [1:0] lookup_hash_select_o, entry_expiry_select_o, odd_port_option_o, even_port_option_o;
    logic [8:0] entry_expiry_secs_o;
    logic [3:0] gap;
    int num_errors, comparisons;

    swc_config_bank #(.IDX_W(6)) i_dut (.core_clk_i, .rst_i, .ce_i, .strap_ctl_one_i,
        .strap_ctl_two_i, .strap_xcvr_i, .ee_word_vld_i, .ee_word_idx_i, .ee_word_i, .ee_done_i,
        .ee_start_o, .ee_valid_o, .cfg_ready_o, .switch_control_one_o, .switch_control_two_o,
        .transceiver_control_o, .broadcast_storm_guard_en_o, .ext_port_duplex_o,
        .ext_port_speed_sel_o, .ext_port_pause_en_o, .ext_port_enable_o,
        .excess_collision_discard_o, .lookup_hash_select_o, .hash_crc_first_o,
        .entry_expiry_select_o, .entry_expiry_secs_o, .forward_everything_o, .short_backoff_en_o,
        .odd_port_option_o, .even_port_option_o, .port7_fiber_o, .port7_fiber_full_o,
        .port6_fiber_o, .port6_fiber_full_o, .remote_fault_en_o, .neg_power_save_en_o,
        .crossover_auto_en_o);

    swc_mem_model i_mem (.core_clk_i, .rst_i, .start_i(ee_start_o), .gap_i(gap),
        .pattern_i(pat), .w2_i(m2), .w3_i(m3), .w4_i(m4), .vld_o(ee_word_vld_i),
        .idx_o(ee_word_idx_i), .word_o(ee_word_i), .done_o(ee_done_i));

    // Free-running 100 MHz clock.
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Counts one comparison and reports a mismatch.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // Compares every field output with the words it should come from.
    task automatic check_fields(input swc_word_t e1, input swc_word_t e2, input swc_word_t e3);
        logic [8:0] secs;
        secs = (e2[4:3] == 2'b00) ? 9'd0 : (e2[4:3] == 2'b01) ? 9'd120 :
               (e2[4:3] == 2'b10) ? 9'd240 : 9'd480;
        check("ctl_one", switch_control_one_o, e1);
        check("ctl_two", switch_control_two_o, e2);
        check("xcvr", transceiver_control_o, e3);
        check("storm", broadcast_storm_guard_en_o, e1[2]);
        check("duplex", ext_port_duplex_o, e2[12]);
        check("speed", ext_port_speed_sel_o, e2[11]);
        check("pause", ext_port_pause_en_o, e2[10]);
        check("ext_en", ext_port_enable_o, e2[9]);
        check("drop", excess_collision_discard_o, e2[7]);
        check("hash", lookup_hash_select_o, e2[6:5]);
        check("crc_first", hash_crc_first_o, e2[6:5] == 2'b10);
        check("expiry", entry_expiry_select_o, e2[4:3]);
        check("secs", entry_expiry_secs_o, secs);
        check("fwd_all", forward_everything_o, e2[2]);
        check("backoff", short_backoff_en_o, e2[1]);
        check("odd", odd_port_option_o, e3[15:14]);
        check("p7_fiber", port7_fiber_o, e3[15] & ~e3[11]);
        check("p7_full", port7_fiber_full_o, e3[15:14] == 2'b10 && !e3[11]);
        check("even", even_port_option_o, e3[13:12]);
        check("p6_fiber", port6_fiber_o, e3[13] & ~e3[11]);
        check("p6_full", port6_fiber_full_o, e3[13:12] == 2'b10 && !e3[11]);
        check("fef", remote_fault_en_o, e3[10]);
        check("pwr_save", neg_power_save_en_o, e3[9]);
        check("xover", crossover_auto_en_o, e3[8]);
    endtask : check_fields

    // Resets, lets straps and the memory pass load, then judges the settled bank.
    task automatic load(input swc_word_t s1, input swc_word_t s2, input swc_word_t s3);
        int n;
        logic ok;
        rst_i = 1'b1;
        strap_ctl_one_i = s1;
        strap_ctl_two_i = s2;
        strap_xcvr_i = s3;
        repeat (4) @(negedge core_clk_i);
        rst_i = 1'b0;
        @(negedge core_clk_i);
        check("start", ee_start_o, 1'b1);
        for (n = 0; n < 80 && cfg_ready_o !== 1'b1; n++) @(negedge core_clk_i);
        if (cfg_ready_o !== 1'b1) begin
            num_errors++;
            complete_run();
        end
        @(negedge core_clk_i);
        ok = (pat == `SWC_ENABLE_PATTERN);
        check("ee_valid", ee_valid_o, ok);
        if (ok) check_fields(m2 & `SWC_MSK_CTL_ONE, m3 & `SWC_MSK_CTL_TWO, m4 & `SWC_MSK_XCVR);
        else check_fields(s1 & `SWC_MSK_CTL_ONE, s2 & `SWC_MSK_CTL_TWO, s3 & `SWC_MSK_XCVR);
    endtask : load

    // Defaults are held while reset is asserted.
    task automatic test_defaults;
        repeat (4) @(negedge core_clk_i);
        check("start_rst", ee_start_o, 1'b0);
        check("ready_rst", cfg_ready_o, 1'b0);
        check_fields(`SWC_RST_CTL_ONE, `SWC_RST_CTL_TWO, `SWC_RST_XCVR);
        $display("test defaults done");
    endtask : test_defaults

    // A wrong enable pattern leaves the strap values in place, slow memory.
    task automatic test_straps_kept;
        pat = 16'h55ab;
        gap = 4'h3;
        m2 = 16'hffff;
        m3 = 16'h0000;
        m4 = 16'h0000;
        load(16'hfffb, 16'h6565, 16'h7d3c);
        $display("test straps_kept done");
    endtask : test_straps_kept

    // A low clock enable freezes the bank, its reset action included.
    task automatic test_freeze;
        ce_i = 1'b0;
        rst_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        check("frz_ready", cfg_ready_o, 1'b1);
        check("frz_two", switch_control_two_o, 16'h6565 & `SWC_MSK_CTL_TWO);
        ce_i = 1'b1;
        $display("test freeze done");
    endtask : test_freeze

    // Every hash, expiry and port option code, reserved bits set, strap values inverted.
    task automatic test_codes;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            pat = `SWC_ENABLE_PATTERN;
            gap = {3'h0, c[0]};
            m2 = {15'h7ffe, c[1]};
            m3 = {3'b101, c[0], c[1], c[0], c[1], 1'b1, ~c[0], c, c, 1'b0, c[0], 1'b1};
            m4 = {c, c, 1'b0, c[0], 1'b1, c[1], 8'hff};
            load(~m2, ~m3, ~m4);
        end
        $display("test codes done");
    endtask : test_codes

    // Main sequence.
    initial begin
        num_errors = 0;
        comparisons = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        gap = 4'h0;
        pat = 16'h0000;
        {m2, m3, m4} = 48'h0;
        {strap_ctl_one_i, strap_ctl_two_i, strap_xcvr_i} = 48'h0;
        test_defaults();
        test_straps_kept();
        test_freeze();
        test_codes();
        complete_run();
    end
endmodule : testbench
